// ==== chg_pkg.sv ====
// shared constants and carriers for the channel guard and access lock
package chg_pkg;

    // ----------------------------------------------------------------
    // parameter addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_EXCL_ACCESS_CTRL = 16'h011A;
    localparam logic [15:0] ADDR_CHAN_WDOG_TIME   = 16'h160C;

    // ----------------------------------------------------------------
    // values and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] WDOG_TIME_RESET = 16'h0000;
    localparam logic [15:0] WDOG_TIME_OFF   = 16'h0000;
    localparam logic [15:0] WDOG_TIME_MAX   = 16'h2710;
    localparam logic [15:0] EXCL_RELEASE    = 16'h0000;
    localparam logic [15:0] EXCL_CLAIM      = 16'h0001;
    localparam logic [3:0]  ERR_CLASS_NONE  = 4'h0;
    localparam logic [3:0]  ERR_CLASS_COMM  = 4'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int WDOG_UNIT_MS  = 1;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CYC_PER_MS    = (WDOG_UNIT_MS * 1000000) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // channel sizing
    // ----------------------------------------------------------------
    localparam int CHAN_W   = 3;
    localparam int MAX_CHAN = 1 << CHAN_W;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [15:0]       addr;
        logic              write;
        logic [15:0]       wdata;
    } chg_req_s;

    typedef struct packed {
        logic [15:0] rdata;
        logic        err;
    } chg_rsp_s;

endpackage

// ==== chg_wdog_chan.sv ====
// one channel's message watchdog with millisecond prescaler
module chg_wdog_chan #(
    parameter int CYC_PER_MS = chg_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // configuration and activity
    input  wire logic [15:0] cfg_ms,
    input  wire logic        load,
    input  wire logic        kick,
    // status
    output logic             active_r,
    output logic             expired_r
);
    import chg_pkg::*;

    localparam int PRE_W = $clog2(CYC_PER_MS + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

    logic [PRE_W-1:0] pre_r;
    logic [15:0]      ms_left_r;
    logic             ms_tick;

    assign ms_tick = (pre_r == PRE_LAST);

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_r     <= '0;
            ms_left_r <= WDOG_TIME_RESET;
            active_r  <= 1'b0;
            expired_r <= 1'b0;
        end else begin
            expired_r <= 1'b0;
            if (load || kick) begin
                // restart from full interval; zero means no monitoring
                pre_r     <= '0;
                ms_left_r <= cfg_ms;                                // [RULE_05] [RULE_11]
                active_r  <= (cfg_ms != WDOG_TIME_OFF);             // [RULE_01]
            end else if (active_r) begin
                if (cfg_ms == WDOG_TIME_OFF) begin
                    active_r <= 1'b0;                               // [RULE_01]
                end else if (ms_tick) begin
                    pre_r <= '0;
                    if (ms_left_r <= 16'h0001) begin
                        active_r  <= 1'b0;
                        expired_r <= 1'b1;                          // [RULE_03]
                    end else begin
                        ms_left_r <= ms_left_r - 16'h0001;          // [RULE_02]
                    end
                end else begin
                    pre_r <= pre_r + PRE_W'(1);
                end
            end
        end
    end

endmodule

// ==== chg_guard_lock.sv ====
// per-channel communication watchdog and exclusive access lock
//
// Summary of operation
// (RULE_01) watchdog time zero disables channel monitoring
// (RULE_02) nonzero time is milliseconds, up to 10000
// (RULE_03) silent enabled channel raises class 2 error
// (RULE_04) watchdog applies to the channel that wrote it
// (RULE_05) new watchdog time acts immediately, no commit
// (RULE_06) write 1 claims, write 0 releases exclusivity
// (RULE_07) read returns 1 only to holding channel
// (RULE_08) state changes need exclusive access first
// (RULE_09) other channels refused while one holds access
// (RULE_10) ethernet link loss detected separately
// (RULE_11) each message restarts the full countdown
module chg_guard_lock #(
    parameter int NUM_CHAN   = 4,
    parameter int CYC_PER_MS = chg_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    // parameter access
    input  wire logic                          req_valid,
    input  wire chg_pkg::chg_req_s             req,
    output logic                               rsp_valid_r,
    output chg_pkg::chg_rsp_s                  rsp_r,
    // message activity
    input  wire logic                          msg_valid,
    input  wire logic [chg_pkg::CHAN_W-1:0]    msg_chan,
    // operating state and mode requests
    input  wire logic                          op_valid,
    input  wire logic [chg_pkg::CHAN_W-1:0]    op_chan,
    output logic                               op_grant_r,
    output logic                               op_refuse_r,
    // link
    input  wire logic                          link_up,
    output logic                               link_lost_r,
    // error reporting
    input  wire logic                          err_clear,
    output logic                               comm_err_r,
    output logic [3:0]                         err_class_r,
    output logic [chg_pkg::MAX_CHAN-1:0]       err_chan_r,
    // lock status
    output logic                               excl_held_r,
    output logic [chg_pkg::CHAN_W-1:0]         excl_owner_r
);
    import chg_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (NUM_CHAN < 1 || NUM_CHAN > MAX_CHAN) begin : g_bad_chan
            $error("NUM_CHAN out of range");
        end
        if (CYC_PER_MS < 1) begin : g_bad_cyc
            $error("CYC_PER_MS must be at least one");
        end
    endgenerate

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    logic        req_chan_ok;
    logic        hit_excl;
    logic        hit_wdog;
    logic        wr_wdog_ok;
    logic        wr_excl_claim;
    logic        wr_excl_release;
    logic        owner_is_req;
    logic        op_chan_ok;

    assign req_chan_ok  = (int'(req.chan) < NUM_CHAN);
    assign hit_excl     = (req.addr == ADDR_EXCL_ACCESS_CTRL);
    assign hit_wdog     = (req.addr == ADDR_CHAN_WDOG_TIME);
    assign owner_is_req = excl_held_r && (excl_owner_r == req.chan);
    assign op_chan_ok   = (int'(op_chan) < NUM_CHAN);

    assign wr_wdog_ok = req_valid && req_chan_ok && req.write && hit_wdog
                        && (req.wdata <= WDOG_TIME_MAX);                  // [RULE_02]
    // a claim is refused while a different channel holds the lock
    assign wr_excl_claim = req_valid && req_chan_ok && req.write && hit_excl
                           && (req.wdata == EXCL_CLAIM)
                           && (!excl_held_r || owner_is_req);
    assign wr_excl_release = req_valid && req_chan_ok && req.write && hit_excl
                             && (req.wdata == EXCL_RELEASE);

    // ----------------------------------------------------------------
    // watchdog time storage, one word per channel
    // ----------------------------------------------------------------
    logic [15:0] wdog_time_r [MAX_CHAN];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MAX_CHAN; i++) begin
                wdog_time_r[i] <= WDOG_TIME_RESET;
            end
        end else if (wr_wdog_ok) begin
            wdog_time_r[req.chan] <= req.wdata;                           // [RULE_04]
        end
    end

    // ----------------------------------------------------------------
    // channel watchdogs
    // ----------------------------------------------------------------
    logic [NUM_CHAN-1:0] chan_expired;
    logic [NUM_CHAN-1:0] chan_active;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            logic        load_g;
            logic        kick_g;
            logic [15:0] cfg_g;
            // register accesses are messages on their channel too
            assign load_g = wr_wdog_ok && (int'(req.chan) == g);          // [RULE_04] [RULE_05]
            // a landing write hands its own value over, the store lags a cycle
            assign cfg_g  = load_g ? req.wdata : wdog_time_r[g];          // [RULE_05]
            assign kick_g = (msg_valid && (int'(msg_chan) == g))
                            || (req_valid && (int'(req.chan) == g));      // [RULE_11]
            chg_wdog_chan #(
                .CYC_PER_MS (CYC_PER_MS)
            ) u_wdog (
                .core_clk  (core_clk),
                .resetn    (resetn),
                .cfg_ms    (cfg_g),
                .load      (load_g),
                .kick      (kick_g),
                .active_r  (chan_active[g]),
                .expired_r (chan_expired[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // communication error, sticky per channel
    // ----------------------------------------------------------------
    logic [MAX_CHAN-1:0] err_set;
    logic [MAX_CHAN-1:0] err_chan_nxt;

    assign err_set      = MAX_CHAN'(chan_expired);
    // a timeout in the clearing cycle survives the clear
    assign err_chan_nxt = (err_chan_r & {MAX_CHAN{~err_clear}}) | err_set;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            err_chan_r  <= '0;
            comm_err_r  <= 1'b0;
            err_class_r <= ERR_CLASS_NONE;
        end else begin
            err_chan_r  <= err_chan_nxt;                                  // [RULE_03]
            comm_err_r  <= |err_chan_nxt;
            err_class_r <= (|err_chan_nxt) ? ERR_CLASS_COMM : ERR_CLASS_NONE; // [RULE_03]
        end
    end

    // ----------------------------------------------------------------
    // exclusive access lock
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            excl_held_r  <= 1'b0;
            excl_owner_r <= '0;
        end else if (wr_excl_claim) begin
            excl_held_r  <= 1'b1;                                         // [RULE_06]
            excl_owner_r <= req.chan;
        end else if (wr_excl_release && owner_is_req) begin
            excl_held_r  <= 1'b0;                                         // [RULE_06]
        end
    end

    // ----------------------------------------------------------------
    // operating state and mode gate
    // ----------------------------------------------------------------
    logic op_allowed;

    assign op_allowed = op_chan_ok && excl_held_r
                        && (excl_owner_r == op_chan);                     // [RULE_08] [RULE_09]

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            op_grant_r  <= 1'b0;
            op_refuse_r <= 1'b0;
        end else begin
            op_grant_r  <= op_valid && op_allowed;
            op_refuse_r <= op_valid && !op_allowed;                       // [RULE_09]
        end
    end

    // ----------------------------------------------------------------
    // parameter access answer
    // ----------------------------------------------------------------
    chg_rsp_s rsp_nxt;

    always_comb begin
        rsp_nxt = '0;
        if (!req_chan_ok || !(hit_excl || hit_wdog)) begin
            rsp_nxt.err = 1'b1;
        end else if (req.write) begin
            if (hit_wdog) begin
                rsp_nxt.err = !wr_wdog_ok;
            end else begin
                rsp_nxt.err = !(wr_excl_claim || wr_excl_release);
            end
        end else if (hit_wdog) begin
            rsp_nxt.rdata = wdog_time_r[req.chan];                        // [RULE_04]
        end else begin
            rsp_nxt.rdata = owner_is_req ? EXCL_CLAIM : EXCL_RELEASE;     // [RULE_07]
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end else begin
            rsp_valid_r <= req_valid;
            rsp_r       <= req_valid ? rsp_nxt : '0;
        end
    end

    // ----------------------------------------------------------------
    // link supervision
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            link_lost_r <= 1'b0;
        end else begin
            link_lost_r <= !link_up;                                      // [RULE_10]
        end
    end

endmodule

// ==== chg_mb_master.sv ====
// modbus tcp master model for parameter access and message traffic
module chg_mb_master (
    // clock
    input  wire logic                  core_clk,
    // parameter access
    output logic                       req_valid,
    output chg_pkg::chg_req_s          req,
    input  wire logic                  rsp_valid_r,
    input  wire chg_pkg::chg_rsp_s     rsp_r,
    // message traffic
    output logic                       msg_valid,
    output logic [chg_pkg::CHAN_W-1:0] msg_chan
);
    timeunit 1ns;
    timeprecision 100ps;
    import chg_pkg::*;

    initial begin
        req_valid = 1'b0;
        req = '0;
        msg_valid = 1'b0;
        msg_chan = '0;
    end

    // one pulse per access; released fields never repeat the last value
    task automatic access(input logic [2:0] c, input logic [15:0] a, input logic w,
                          input logic [15:0] d, output logic [15:0] rd, output logic e);
        @(negedge core_clk);
        req_valid = 1'b1;
        req = '{chan: c, addr: a, write: w, wdata: d};
        @(negedge core_clk);
        req_valid = 1'b0;
        req = ~req;
        rd = rsp_r.rdata;
        e = rsp_valid_r ? rsp_r.err : 1'bx;
    endtask

    task automatic message(input logic [2:0] c);
        @(negedge core_clk);
        msg_valid = 1'b1;
        msg_chan = c;
        @(negedge core_clk);
        msg_valid = 1'b0;
        msg_chan = ~c;
    endtask
endmodule

// ==== chg_guard_lock_props.sv ====
// port assertions for the channel guard and access lock
module chg_guard_lock_props
    import chg_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                resetn,
    // access and status
    input wire logic                req_valid,
    input wire chg_req_s            req,
    input wire logic                rsp_valid_r,
    input wire chg_rsp_s            rsp_r,
    input wire logic                op_valid,
    input wire logic [CHAN_W-1:0]   op_chan,
    input wire logic                op_grant_r,
    input wire logic                op_refuse_r,
    input wire logic                link_up,
    input wire logic                link_lost_r,
    input wire logic                err_clear,
    input wire logic                comm_err_r,
    input wire logic [3:0]          err_class_r,
    input wire logic [MAX_CHAN-1:0] err_chan_r,
    input wire logic                excl_held_r,
    input wire logic [CHAN_W-1:0]   excl_owner_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    logic excl_acc;
    logic own_req;
    assign excl_acc = req_valid && req.addr == ADDR_EXCL_ACCESS_CTRL && req.chan < NUM_CHAN;
    assign own_req = excl_held_r && excl_owner_r == req.chan;

    property p_rsp_once;
        req_valid ##1 !req_valid |-> rsp_valid_r ##1 !rsp_valid_r;
    endproperty
    a_rsp_once: assert property (p_rsp_once) else $error("answer strobe wrong");
    property p_claim;
        excl_acc && req.write && req.wdata == EXCL_CLAIM && !excl_held_r
            |=> excl_held_r && excl_owner_r == $past(req.chan) && !rsp_r.err;
    endproperty
    a_claim: assert property (p_claim) else $error("claim not taken");
    property p_release;
        excl_acc && req.write && req.wdata == EXCL_RELEASE && own_req |=> !excl_held_r;
    endproperty
    a_release: assert property (p_release) else $error("release not taken");
    property p_read;
        excl_acc && !req.write |=> rsp_r.rdata == {15'h0000, $past(own_req)};
    endproperty
    a_read: assert property (p_read) else $error("lock readback wrong");
    property p_steal;
        excl_acc && req.write && excl_held_r && !own_req && req.wdata == EXCL_CLAIM
            |=> rsp_r.err && excl_owner_r == $past(excl_owner_r);
    endproperty
    a_steal: assert property (p_steal) else $error("foreign claim taken");
    property p_grant;
        op_valid && excl_held_r && excl_owner_r == op_chan |=> op_grant_r && !op_refuse_r;
    endproperty
    a_grant: assert property (p_grant) else $error("owner request not granted");
    property p_refuse;
        op_valid && !(excl_held_r && excl_owner_r == op_chan) |=> op_refuse_r && !op_grant_r;
    endproperty
    a_refuse: assert property (p_refuse) else $error("request not refused");
    property p_wdog_max;
        req_valid && req.write && req.addr == ADDR_CHAN_WDOG_TIME && req.wdata > WDOG_TIME_MAX
            |=> rsp_r.err;
    endproperty
    a_wdog_max: assert property (p_wdog_max) else $error("oversize time taken");
    property p_class;
        comm_err_r == (err_chan_r != '0)
            && err_class_r == (comm_err_r ? ERR_CLASS_COMM : ERR_CLASS_NONE);
    endproperty
    a_class: assert property (p_class) else $error("error class wrong");
    property p_sticky;
        !$past(err_clear) |-> (err_chan_r & $past(err_chan_r)) == $past(err_chan_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("timeout bit lost");
    property p_link;
        link_up == $past(link_up) |-> link_lost_r == !link_up;
    endproperty
    a_link: assert property (p_link) else $error("link loss wrong");
endmodule

bind chg_guard_lock chg_guard_lock_props #(.NUM_CHAN(NUM_CHAN)) i_props (
    .core_clk, .resetn, .req_valid, .req, .rsp_valid_r, .rsp_r, .op_valid, .op_chan,
    .op_grant_r, .op_refuse_r, .link_up, .link_lost_r, .err_clear, .comm_err_r,
    .err_class_r, .err_chan_r, .excl_held_r, .excl_owner_r
);

// ==== tb_top.sv ====
// self-checking bench for the channel guard and access lock
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import chg_pkg::*;
    localparam logic [15:0] WDA = ADDR_CHAN_WDOG_TIME;
    localparam logic [15:0] EXA = ADDR_EXCL_ACCESS_CTRL;
    logic core_clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, link_up = 1'b1, err_clear = 1'b0;
    logic [CHAN_W-1:0] op_chan = '0;
    logic req_valid, rsp_valid_r, msg_valid, op_grant_r, op_refuse_r, link_lost_r;
    logic comm_err_r, excl_held_r, er;
    chg_req_s req;
    chg_rsp_s rsp_r;
    logic [CHAN_W-1:0] msg_chan, excl_owner_r;
    logic [3:0] err_class_r;
    logic [MAX_CHAN-1:0] err_chan_r;
    logic [15:0] rd;
    int miscompares = 0;
    int checks_done = 0;

    always #25 core_clk = ~core_clk;

    chg_guard_lock #(.NUM_CHAN(4), .CYC_PER_MS(4)) i_dut (
        .core_clk, .resetn, .req_valid, .req, .rsp_valid_r, .rsp_r, .msg_valid, .msg_chan,
        .op_valid, .op_chan, .op_grant_r, .op_refuse_r, .link_up, .link_lost_r, .err_clear,
        .comm_err_r, .err_class_r, .err_chan_r, .excl_held_r, .excl_owner_r
    );
    chg_mb_master i_mst (
        .core_clk, .req_valid, .req, .rsp_valid_r, .rsp_r, .msg_valid, .msg_chan
    );

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic [2:0] c, input logic [15:0] a, input logic w,
                       input logic [15:0] d, input logic [15:0] ed, input logic ee);
        i_mst.access(c, a, w, d, rd, er);
        chk("rsp_err", {15'h0000, ee}, {15'h0000, er});
        if (!w) begin
            chk("rdata", ed, rd);
        end
    endtask
    task automatic op(input logic [2:0] c, input logic g);
        @(negedge core_clk);
        op_valid = 1'b1;
        op_chan = c;
        @(negedge core_clk);
        op_valid = 1'b0;
        chk("op_grant", {15'h0000, g}, {15'h0000, op_grant_r});
        chk("op_refuse", {15'h0000, !g}, {15'h0000, op_refuse_r});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic end_of_test;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        end_of_test();
    end

    initial begin
        idle(8);
        resetn = 1'b1;
        acc(3'h0, WDA, 1'b0, 16'h0000, WDOG_TIME_RESET, 1'b0);
        acc(3'h0, WDA, 1'b1, WDOG_TIME_MAX, 16'h0000, 1'b0);
        acc(3'h0, WDA, 1'b1, 16'h2711, 16'h0000, 1'b1);
        acc(3'h0, WDA, 1'b0, 16'h0000, WDOG_TIME_MAX, 1'b0);
        acc(3'h0, WDA, 1'b1, WDOG_TIME_OFF, 16'h0000, 1'b0);
        acc(3'h7, WDA, 1'b0, 16'h0000, 16'h0000, 1'b1);
        acc(3'h0, 16'h0001, 1'b0, 16'h0000, 16'h0000, 1'b1);
        idle(40);
        chk("err_chan", 16'h0000, {8'h00, err_chan_r});
        $display("test config done");
        acc(3'h2, WDA, 1'b1, 16'h0002, 16'h0000, 1'b0);
        repeat (5) begin
            idle(4);
            i_mst.message(3'h2);
        end
        idle(6);
        chk("err_chan", 16'h0000, {8'h00, err_chan_r});
        idle(6);
        chk("err_chan", 16'h0004, {8'h00, err_chan_r});
        chk("err_class", {12'h000, ERR_CLASS_COMM}, {12'h000, err_class_r});
        chk("comm_err", 16'h0001, {15'h0000, comm_err_r});
        acc(3'h3, WDA, 1'b1, WDOG_TIME_MAX, 16'h0000, 1'b0);
        acc(3'h3, WDA, 1'b1, 16'h0001, 16'h0000, 1'b0);
        idle(8);
        chk("err_chan", 16'h000C, {8'h00, err_chan_r});
        err_clear = 1'b1;
        idle(1);
        err_clear = 1'b0;
        chk("err_class", 16'h0000, {12'h000, err_class_r});
        chk("comm_err", 16'h0000, {15'h0000, comm_err_r});
        acc(3'h2, WDA, 1'b1, WDOG_TIME_OFF, 16'h0000, 1'b0);
        acc(3'h3, WDA, 1'b1, WDOG_TIME_OFF, 16'h0000, 1'b0);
        $display("test watchdog done");
        acc(3'h1, EXA, 1'b1, EXCL_CLAIM, 16'h0000, 1'b0);
        acc(3'h1, EXA, 1'b0, 16'h0000, 16'h0001, 1'b0);
        chk("excl_held", 16'h0001, {15'h0000, excl_held_r});
        chk("excl_owner", 16'h0001, {13'h0000, excl_owner_r});
        acc(3'h2, EXA, 1'b0, 16'h0000, 16'h0000, 1'b0);
        acc(3'h2, EXA, 1'b1, EXCL_CLAIM, 16'h0000, 1'b1);
        acc(3'h2, EXA, 1'b1, EXCL_RELEASE, 16'h0000, 1'b0);
        op(3'h1, 1'b1);
        op(3'h2, 1'b0);
        acc(3'h1, EXA, 1'b1, 16'h0002, 16'h0000, 1'b1);
        acc(3'h1, EXA, 1'b0, 16'h0000, 16'h0001, 1'b0);
        acc(3'h1, EXA, 1'b1, EXCL_RELEASE, 16'h0000, 1'b0);
        op(3'h1, 1'b0);
        acc(3'h1, EXA, 1'b0, 16'h0000, 16'h0000, 1'b0);
        chk("excl_held", 16'h0000, {15'h0000, excl_held_r});
        $display("test lock done");
        link_up = 1'b0;
        idle(2);
        chk("link_lost", 16'h0001, {15'h0000, link_lost_r});
        link_up = 1'b1;
        idle(2);
        chk("link_lost", 16'h0000, {15'h0000, link_lost_r});
        $display("test link done");
        end_of_test();
    end
endmodule
